/* logic/single_wire_pkg.sv */
// constants and types shared by the single-wire slave protocol engine
package single_wire_pkg;
    // line timing in microseconds and derived cycle counts at 100 MHz
    localparam int unsigned CLK_MHZ                   = 100;
    localparam int unsigned RESET_LOW_TIME_US         = 480;
    localparam int unsigned PRESENCE_WAIT_TIME_US     = 30;
    localparam int unsigned PRESENCE_LOW_TIME_US      = 120;
    localparam int unsigned SAMPLE_DELAY_US           = 30;
    localparam int unsigned READ_HOLD_US              = 15;
    localparam int unsigned INT_LOW_TIME_US           = 1920;
    localparam int unsigned RESET_LOW_CYCLES          = RESET_LOW_TIME_US * CLK_MHZ;
    localparam int unsigned PRESENCE_WAIT_CYCLES      = PRESENCE_WAIT_TIME_US * CLK_MHZ;
    localparam int unsigned PRESENCE_LOW_CYCLES       = PRESENCE_LOW_TIME_US * CLK_MHZ;
    localparam int unsigned SAMPLE_DELAY_CYCLES       = SAMPLE_DELAY_US * CLK_MHZ;
    localparam int unsigned READ_HOLD_CYCLES          = READ_HOLD_US * CLK_MHZ;
    localparam int unsigned INT_LOW_CYCLES            = INT_LOW_TIME_US * CLK_MHZ;
    localparam int unsigned TIMER_W                   = 20;

    // identity layout
    localparam int unsigned ID_W                      = 64;

    // command codes
    localparam logic [7:0] CMD_READ_ID                = 8'h33;
    localparam logic [7:0] CMD_SELECT                 = 8'h55;
    localparam logic [7:0] CMD_BYPASS                 = 8'hcc;
    localparam logic [7:0] CMD_SEARCH                 = 8'hf0;
    localparam logic [7:0] CMD_ALARM_SEARCH           = 8'hec;

    // register map
    localparam logic [9:0] ALARM_STATUS_ADDR          = 10'h200;
    localparam logic [7:0] ALARM_STATUS_RESET         = 8'h00;
    localparam int unsigned ALARM_W                   = 8;

    // buffer for bytes handed to the memory layer
    localparam int unsigned BUF_DEPTH                 = 2;
    localparam int unsigned BYTE_W                    = 8;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'b0000001,
        ST_CMD      = 7'b0000010,
        ST_SEND_ID  = 7'b0000100,
        ST_MATCH    = 7'b0001000,
        ST_SEARCH   = 7'b0010000,
        ST_MEMORY   = 7'b0100000,
        ST_WAIT_RST = 7'b1000000
    } rom_state_type;

    typedef enum logic [3:0] {
        LN_IDLE     = 4'b0001,
        LN_PWAIT    = 4'b0010,
        LN_PLOW     = 4'b0100,
        LN_INT      = 4'b1000
    } line_state_type;

    // search phases: bit, complement, master write
    typedef enum logic [2:0] {
        SP_BIT      = 3'b001,
        SP_CMP      = 3'b010,
        SP_WRITE    = 3'b100
    } search_phase_type;

    function automatic logic [TIMER_W-1:0] cyc(input int unsigned n);
        return n[TIMER_W-1:0];
    endfunction
endpackage

/* logic/line_sync.sv */
// two-flop synchroniser and edge detect for the open-drain line
`timescale 1ns/1ps
module line_sync (
    input  wire logic i_mclk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_line,
    output logic      o_level,
    output logic      o_fall,
    output logic      o_rise
);
    logic meta;
    logic sync;
    logic prev;

    // meta feeds only sync
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end else if (i_ce) begin
            meta <= i_line;
            sync <= meta;
            prev <= sync;
        end
    end

    assign o_level = sync;
    assign o_fall  = prev & ~sync;
    assign o_rise  = ~prev & sync;
endmodule

/* logic/byte_buffer.sv */
// two-entry valid/ready buffer for received memory-layer bytes
`timescale 1ns/1ps
module byte_buffer
    import single_wire_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    input  wire logic              i_valid,
    output logic                   o_ready,
    input  wire logic [BYTE_W-1:0] i_data,
    output logic                   o_valid,
    input  wire logic              i_ready,
    output logic [BYTE_W-1:0]      o_data
);
    logic [BYTE_W-1:0] mem [BUF_DEPTH];
    logic              wr_ptr;
    logic              rd_ptr;
    logic [1:0]        count;
    logic              push;
    logic              pop;

    assign o_ready = (count != 2'd2);
    assign o_valid = (count != 2'd0);
    assign o_data  = mem[rd_ptr];
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'd0;
        end else if (i_ce) begin
            if (push) begin
                mem[wr_ptr] <= i_data;
                wr_ptr      <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

/* logic/single_wire_slave.sv */
// slave protocol engine: reset/presence, identity commands, slots, alarms
// Notes on behaviour
// - reset, identity command, memory command, then data
// - after rise wait, then drive presence low
// - identity commands are eight bits after presence
// - 33h sends family, serial and check value
// - 55h: only exact identity match continues
// - CCh goes straight to memory commands
// - search: send bit, complement, read master choice
// - ECh searches only with unacknowledged interrupt
// - output is open drain, wired-and
// - master starts all slots, device only pulses
// - write slot sampled after falling-edge delay
// - read zero held low, one left untouched
// - read level valid within 1, until 15 us
// - alarm event sets its status flag
// - interrupt active when flag and enable both set
// - reading 200h clears flags; enable clear ends interrupt
// - reset after idle arms; any fall outside presence wait and own presence/interrupt pulses disarms
// - alarm while disarmed becomes a delayed interrupt
// - armed interrupt: long low, then presence
// - alarm during presence waits until it ends
// - delayed interrupt stretches next reset low time
// - unacknowledged interrupt repeats on every reset
`timescale 1ns/1ps
module single_wire_slave
    import single_wire_pkg::*;
(
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    input  wire logic               i_ce,
    input  wire logic               i_line,
    output logic                    o_line,
    output logic                    o_line_oe_n,
    input  wire logic [ID_W-1:0]    i_identity,
    input  wire logic [ALARM_W-1:0] i_alarm_event,
    input  wire logic [ALARM_W-1:0] i_int_enable,
    input  wire logic [9:0]         i_reg_addr,
    input  wire logic               i_reg_read,
    output logic [ALARM_W-1:0]      o_reg_rdata,
    output logic                    o_mem_valid,
    input  wire logic               i_mem_ready,
    output logic [BYTE_W-1:0]       o_mem_data,
    output logic                    o_selected,
    output logic                    o_int_active
);
    logic               lvl, fall, rise, slot_active, drive_zero, reset_seen;
    logic               tx_bit, sample_now, rx_bit, int_cond, int_prev, armed;
    logic               int_pending, buf_valid, buf_ready, mem_valid_c;
    line_state_type     line_state;
    rom_state_type      rom_state;
    search_phase_type   sphase;
    logic [TIMER_W-1:0] line_timer, low_timer, slot_timer;
    logic [6:0]         bit_idx;
    logic [7:0]         cmd_shift, mem_shift;
    logic [2:0]         mem_bits;
    logic [ALARM_W-1:0] alarm_status;
    logic [BYTE_W-1:0]  mem_data_c;

    line_sync u_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_line  (i_line),
        .o_level (lvl),
        .o_fall  (fall),
        .o_rise  (rise)
    );

    // long low on the line marks a reset pulse regardless of protocol state
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            low_timer  <= '0;
            reset_seen <= 1'b0;
        end else if (i_ce) begin
            if (lvl) begin
                low_timer <= '0;
            end else if (low_timer != cyc(RESET_LOW_CYCLES)) begin
                low_timer <= low_timer + 1'b1;
            end
            reset_seen <= (low_timer == cyc(RESET_LOW_CYCLES) - 1'b1) & ~lvl;
        end
    end

    assign int_cond = |(alarm_status & i_int_enable);

    // alarm flags: event set wins over the read clear
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            alarm_status <= ALARM_STATUS_RESET;
            o_reg_rdata  <= '0;
            o_int_active <= 1'b0;
        end else if (i_ce) begin
            if (i_reg_read && i_reg_addr == ALARM_STATUS_ADDR) begin
                alarm_status <= i_alarm_event;
            end else begin
                alarm_status <= alarm_status | i_alarm_event;
            end
            o_reg_rdata  <= (i_reg_addr == ALARM_STATUS_ADDR) ? alarm_status : '0;
            o_int_active <= int_cond;
        end
    end

    // arm on reset rise; own pulse lows skip the disarm, else arming never lasts
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            armed       <= 1'b0;
            int_prev    <= 1'b0;
            int_pending <= 1'b0;
        end else if (i_ce) begin
            if (fall && line_state == LN_IDLE) begin
                armed <= 1'b0;
            end else if (rise && line_state == LN_IDLE && low_timer == cyc(RESET_LOW_CYCLES)
                         && (rom_state == ST_IDLE || rom_state == ST_WAIT_RST)) begin
                armed <= 1'b1;
            end
            int_prev <= int_cond;
            if (!int_cond || line_state == LN_INT) begin
                int_pending <= 1'b0;
            end else if (int_cond && !int_prev && armed) begin
                int_pending <= 1'b1;
            end
        end
    end

    // line driver: presence, interrupt pulse, reset stretch
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            line_state <= LN_IDLE;
            line_timer <= '0;
        end else if (i_ce) begin
            case (line_state)
                LN_IDLE: begin
                    line_timer <= '0;
                    if (int_pending && lvl) begin
                        line_state <= LN_INT;
                    end else if (reset_seen && int_cond) begin
                        line_state <= LN_INT;
                    end else if (rise && low_timer == cyc(RESET_LOW_CYCLES)) begin
                        line_state <= LN_PWAIT;
                    end
                end
                LN_PWAIT: begin
                    line_timer <= line_timer + 1'b1;
                    if (line_timer == cyc(PRESENCE_WAIT_CYCLES) - 1'b1) begin
                        line_state <= LN_PLOW;
                        line_timer <= '0;
                    end
                end
                LN_PLOW: begin
                    line_timer <= line_timer + 1'b1;
                    if (line_timer == cyc(PRESENCE_LOW_CYCLES) - 1'b1) begin
                        line_state <= LN_IDLE;
                        line_timer <= '0;
                    end
                end
                LN_INT: begin
                    line_timer <= line_timer + 1'b1;
                    if (line_timer == cyc(INT_LOW_CYCLES) - 1'b1) begin
                        line_state <= LN_PWAIT;
                        line_timer <= '0;
                    end
                end
                default: line_state <= LN_IDLE;
            endcase
        end
    end

    // slot timer starts on the master's falling edge
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            slot_timer  <= '0;
            slot_active <= 1'b0;
            drive_zero  <= 1'b0;
        end else if (i_ce) begin
            // read zero: pull right after the edge, hold through the valid window
            if (fall && line_state == LN_IDLE && !tx_bit) begin
                drive_zero <= 1'b1;
            end else if (slot_active && slot_timer == cyc(READ_HOLD_CYCLES)) begin
                drive_zero <= 1'b0;
            end
            if (fall && line_state == LN_IDLE) begin
                slot_timer  <= '0;
                slot_active <= 1'b1;
            end else if (slot_active) begin
                slot_timer <= slot_timer + 1'b1;
                if (slot_timer == cyc(SAMPLE_DELAY_CYCLES) - 1'b1) begin
                    slot_active <= 1'b0;
                end
            end
        end
    end

    assign sample_now = slot_active && slot_timer == cyc(SAMPLE_DELAY_CYCLES) - 1'b1;
    assign rx_bit     = lvl;

    // current transmit bit for read slots
    always_comb begin
        tx_bit = 1'b1;
        if (rom_state == ST_SEND_ID || (rom_state == ST_SEARCH && sphase == SP_BIT)) begin
            tx_bit = i_identity[bit_idx[5:0]];
        end else if (rom_state == ST_SEARCH && sphase == SP_CMP) begin
            tx_bit = ~i_identity[bit_idx[5:0]];
        end
    end

    // open drain: only ever pull low, else release (oe_n high)
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_line      <= 1'b0;
            o_line_oe_n <= 1'b1;
        end else if (i_ce) begin
            o_line      <= 1'b0;
            o_line_oe_n <= ~(drive_zero || line_state == LN_PLOW || line_state == LN_INT
                             || (fall && line_state == LN_IDLE && !tx_bit));
        end
    end
    // identity-layer state machine
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rom_state <= ST_IDLE;
            sphase    <= SP_BIT;
            bit_idx   <= '0;
            cmd_shift <= '0;
        end else if (i_ce) begin
            if (line_state == LN_PLOW) begin
                rom_state <= ST_CMD;
                bit_idx   <= '0;
                sphase    <= SP_BIT;
            end else if (reset_seen) begin
                rom_state <= ST_IDLE;
            end else if (sample_now) begin
                case (rom_state)
                    ST_CMD: begin
                        cmd_shift <= {rx_bit, cmd_shift[7:1]};
                        bit_idx   <= bit_idx + 1'b1;
                        if (bit_idx == 7'd7) begin
                            bit_idx <= '0;
                            case ({rx_bit, cmd_shift[7:1]})
                                CMD_READ_ID:      rom_state <= ST_SEND_ID;
                                CMD_SELECT:       rom_state <= ST_MATCH;
                                CMD_BYPASS:       rom_state <= ST_MEMORY;
                                CMD_SEARCH:       rom_state <= ST_SEARCH;
                                CMD_ALARM_SEARCH: rom_state <= int_cond ? ST_SEARCH
                                                                        : ST_WAIT_RST;
                                default:          rom_state <= ST_WAIT_RST;
                            endcase
                        end
                    end
                    ST_SEND_ID: begin
                        bit_idx <= bit_idx + 1'b1;
                        if (bit_idx == 7'd63) begin
                            rom_state <= ST_MEMORY;
                        end
                    end
                    ST_MATCH: begin
                        bit_idx <= bit_idx + 1'b1;
                        if (rx_bit != i_identity[bit_idx[5:0]]) begin
                            rom_state <= ST_WAIT_RST;
                        end else if (bit_idx == 7'd63) begin
                            rom_state <= ST_MEMORY;
                        end
                    end
                    ST_SEARCH: begin
                        case (sphase)
                            SP_BIT: sphase <= SP_CMP;
                            SP_CMP: sphase <= SP_WRITE;
                            SP_WRITE: begin
                                sphase  <= SP_BIT;
                                bit_idx <= bit_idx + 1'b1;
                                if (rx_bit != i_identity[bit_idx[5:0]]) begin
                                    rom_state <= ST_WAIT_RST;
                                end else if (bit_idx == 7'd63) begin
                                    rom_state <= ST_MEMORY;
                                end
                            end
                            default: sphase <= SP_BIT;
                        endcase
                    end
                    default: rom_state <= rom_state;
                endcase
            end
        end
    end

    // memory-layer bytes collected lsb first into the buffer
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            mem_shift <= '0;
            mem_bits  <= '0;
            buf_valid <= 1'b0;
        end else if (i_ce) begin
            if (buf_valid && buf_ready) begin
                buf_valid <= 1'b0;
            end
            if (rom_state != ST_MEMORY) begin
                mem_bits <= '0;
            end else if (sample_now && !buf_valid) begin
                mem_shift <= {rx_bit, mem_shift[7:1]};
                mem_bits  <= mem_bits + 1'b1;
                buf_valid <= (mem_bits == 3'd7);
            end
        end
    end

    byte_buffer u_buf (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_valid (buf_valid),
        .o_ready (buf_ready),
        .i_data  (mem_shift),
        .o_valid (mem_valid_c),
        .i_ready (i_mem_ready & o_mem_valid),
        .o_data  (mem_data_c)
    );
    // registered memory-side outputs
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_mem_valid <= 1'b0;
            o_mem_data  <= '0;
            o_selected  <= 1'b0;
        end else if (i_ce) begin
            o_mem_valid <= mem_valid_c & ~(o_mem_valid & i_mem_ready);
            o_mem_data  <= mem_data_c;
            o_selected  <= (rom_state == ST_MEMORY);
        end
    end
endmodule

/* verif/single_wire_slave_sva.sv */
// concurrent checks on the single-wire slave engine ports
`timescale 1ns/1ps
module single_wire_slave_sva
    import single_wire_pkg::*;
(
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    input  wire logic               i_ce,
    input  wire logic               i_line,
    input  wire logic               o_line,
    input  wire logic               o_line_oe_n,
    input  wire logic [ALARM_W-1:0] i_alarm_event,
    input  wire logic [ALARM_W-1:0] i_int_enable,
    input  wire logic [9:0]         i_reg_addr,
    input  wire logic               i_reg_read,
    input  wire logic [ALARM_W-1:0] o_reg_rdata,
    input  wire logic               o_mem_valid,
    input  wire logic               i_mem_ready,
    input  wire logic [BYTE_W-1:0]  o_mem_data,
    input  wire logic               o_selected,
    input  wire logic               o_int_active
);
    logic [19:0] drive_cnt;
    logic [19:0] hi_cnt;
    logic [19:0] lo_cnt;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // hi_cnt and lo_cnt saturate far above the longest legal pulse; drive_cnt wraps
    always_ff @(posedge i_mclk) begin
        drive_cnt <= (i_rst || o_line_oe_n) ? 20'h0 : drive_cnt + 20'h1;
    end
    always_ff @(posedge i_mclk) begin
        hi_cnt <= (i_rst || !i_line) ? 20'h0 : hi_cnt + {19'h0, hi_cnt != 20'hfffff};
    end
    always_ff @(posedge i_mclk) begin
        lo_cnt <= (i_rst || i_line) ? 20'h0 : lo_cnt + {19'h0, lo_cnt != 20'hfffff};
    end
    open_drain_a: assert property (o_line == 1'b0)
        else $error("line drive value not low");
    reset_release_a: assert property (disable iff (1'b0) i_rst |=>
        o_line_oe_n && !o_selected && !o_int_active && !o_mem_valid)
        else $error("outputs active after reset");
    unmapped_read_a: assert property (i_ce && i_reg_read &&
        i_reg_addr != ALARM_STATUS_ADDR |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    enable_off_a: assert property (i_ce && i_int_enable == 8'h00 ##1
        i_int_enable == 8'h00 |=> !o_int_active)
        else $error("interrupt active with enables clear");
    ack_clear_a: assert property ((i_ce && i_reg_read &&
        i_reg_addr == ALARM_STATUS_ADDR && i_alarm_event == 8'h00)
        ##1 (i_alarm_event == 8'h00) [*2] |=> !o_int_active)
        else $error("interrupt stays after status read");
    low_width_a: assert property ($rose(o_line_oe_n) |->
        (drive_cnt >= 1490 && drive_cnt <= 24000) ||
        (drive_cnt >= 96000 && drive_cnt <= 384000))
        else $error("device low pulse width out of range");
    presence_wait_a: assert property ($fell(o_line_oe_n) && $past(i_line) &&
        !o_int_active |-> hi_cnt >= 1490)
        else $error("presence started too early");
    buffer_hold_a: assert property (i_ce && o_mem_valid && !i_mem_ready |=>
        o_mem_valid && $stable(o_mem_data))
        else $error("buffered byte lost under stall");
    select_keep_a: assert property (i_ce && o_selected && lo_cnt < 40000 |=>
        o_selected)
        else $error("selection dropped without reset");
endmodule
bind single_wire_slave single_wire_slave_sva u_sva (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_line(i_line), .o_line(o_line),
    .o_line_oe_n(o_line_oe_n), .i_alarm_event(i_alarm_event),
    .i_int_enable(i_int_enable), .i_reg_addr(i_reg_addr), .i_reg_read(i_reg_read),
    .o_reg_rdata(o_reg_rdata), .o_mem_valid(o_mem_valid), .i_mem_ready(i_mem_ready),
    .o_mem_data(o_mem_data), .o_selected(o_selected), .o_int_active(o_int_active)
);

/* verif/line_master.sv */
// behavioural bus master: reset pulses and write slots on the shared line
`timescale 1ns/1ps
module line_master (
    input  wire logic i_mclk,
    output logic      o_pull
);
    initial o_pull = 1'b0;
    // low time kept short of the interrupt masking limit
    task automatic reset_pulse();
        @(negedge i_mclk);
        o_pull = 1'b1;
        repeat (48100) @(negedge i_mclk);
        o_pull = 1'b0;
    endtask
    task automatic write_bit(input logic b);
        @(negedge i_mclk);
        o_pull = 1'b1;
        repeat (b ? 500 : 6000) @(negedge i_mclk);
        o_pull = 1'b0;
        repeat (b ? 5500 : 100) @(negedge i_mclk);
    endtask
endmodule

/* verif/tb.sv */
// self-checking bench for the single-wire slave engine
`timescale 1ns/1ps
module tb
    import single_wire_pkg::*;
;
    logic               mclk;
    logic               rst;
    logic               line;
    logic               pull;
    logic               o_line;
    logic               oe_n;
    logic [ALARM_W-1:0] alarm_event;
    logic [ALARM_W-1:0] int_enable;
    logic [9:0]         reg_addr;
    logic               reg_read;
    logic [ALARM_W-1:0] reg_rdata;
    logic               mem_valid;
    logic [BYTE_W-1:0]  mem_data;
    logic               selected;
    logic               int_active;
    int                 n_mismatch;
    int                 checked;
    int                 n;
    // pull-up wins unless someone pulls low
    assign line = !(pull || (!oe_n && !o_line));
    line_master u_master (.i_mclk(mclk), .o_pull(pull));
    single_wire_slave u_dut (
        .i_mclk(mclk), .i_rst(rst), .i_ce(1'b1), .i_line(line), .o_line(o_line),
        .o_line_oe_n(oe_n), .i_identity(64'h0123456789abcdef),
        .i_alarm_event(alarm_event), .i_int_enable(int_enable), .i_reg_addr(reg_addr),
        .i_reg_read(reg_read), .o_reg_rdata(reg_rdata), .o_mem_valid(mem_valid),
        .i_mem_ready(1'b1), .o_mem_data(mem_data), .o_selected(selected),
        .o_int_active(int_active)
    );
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic final_report();
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_range(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    // bounded wait for the device drive to reach a level
    task automatic wait_oe(input logic lvl, input int limit, output int cnt);
        cnt = 0;
        while (oe_n !== lvl) begin
            @(negedge mclk);
            cnt++;
            if (cnt > limit) begin
                n_mismatch++;
                final_report();
            end
        end
    endtask
    task automatic read_reg(input logic [9:0] addr);
        @(negedge mclk);
        reg_addr = addr;
        reg_read = 1'b1;
        @(negedge mclk);
        reg_read = 1'b0;
    endtask
    task automatic pulse_alarm(input logic [7:0] ev, input logic [7:0] en);
        @(negedge mclk);
        alarm_event = ev;
        int_enable = en;
        @(negedge mclk);
        alarm_event = 8'h00;
        repeat (3) @(negedge mclk);
    endtask
    task automatic alarm_scenario();
        read_reg(10'h1ff);
        check(reg_rdata, 8'h00);
        pulse_alarm(8'h04, 8'h04);
        check({7'h0, int_active}, 8'h01);
        read_reg(ALARM_STATUS_ADDR);
        check(reg_rdata, 8'h04);
        repeat (3) @(negedge mclk);
        check({7'h0, int_active}, 8'h00);
        pulse_alarm(8'h81, 8'h04);
        check({7'h0, int_active}, 8'h00);
        pulse_alarm(8'h00, 8'h81);
        check({7'h0, int_active}, 8'h01);
        pulse_alarm(8'h00, 8'h00);
        check({7'h0, int_active}, 8'h00);
        read_reg(ALARM_STATUS_ADDR);
        check(reg_rdata, 8'h81);
        read_reg(ALARM_STATUS_ADDR);
        check(reg_rdata, 8'h00);
    endtask
    task automatic presence_scenario();
        u_master.reset_pulse();
        wait_oe(1'b0, 10000, n);
        check_range(n, 1500, 6000);
        wait_oe(1'b1, 30000, n);
        check_range(n, 6000, 24000);
        check({7'h0, line}, 8'h01);
        check({7'h0, selected}, 8'h00);
    endtask
    task automatic bypass_scenario();
        repeat (100) @(negedge mclk);
        for (int i = 0; i < 8; i++) begin
            u_master.write_bit(CMD_BYPASS[i]);
        end
        repeat (20) @(negedge mclk);
        check({7'h0, selected}, 8'h01);
        check({7'h0, oe_n}, 8'h01);
        check({7'h0, mem_valid}, 8'h00);
    endtask
    initial begin
        rst = 1'b1;
        alarm_event = 8'h00;
        int_enable = 8'h00;
        reg_addr = 10'h000;
        reg_read = 1'b0;
        n_mismatch = 0;
        checked = 0;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        alarm_scenario();
        presence_scenario();
        bypass_scenario();
        final_report();
    end
endmodule
